// *** src/cca_pkg.sv ***
// Register map, field layouts and constants of the counter array channels
package cca_pkg;
   localparam int NCH = 3;

   // Byte addresses on the register bus
   localparam logic [7:0] REG_MODE  = 8'h00;
   localparam logic [7:0] REG_FLAG  = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam logic [7:0] REG_POL   = 8'h0C;
   // Channel n sits at 0x10 * (n + 1); offsets inside a channel
   localparam logic [3:0] CH_FIRST  = 4'h1;
   localparam logic [3:0] OFS_CFG   = 4'h0;
   localparam logic [3:0] OFS_LOW   = 4'h4;
   localparam logic [3:0] OFS_HIGH  = 4'h8;

   // Timebase codes
   localparam logic [2:0] TB_DIV12 = 3'h0;
   localparam logic [2:0] TB_DIV4  = 3'h1;
   localparam logic [2:0] TB_TMR   = 3'h2;
   localparam logic [2:0] TB_ECI   = 3'h3;
   localparam logic [2:0] TB_SYS   = 3'h4;
   localparam logic [2:0] TB_EXT8  = 3'h5;
   localparam logic [2:0] TB_LFO8  = 3'h6;

   // Prescaler counts 0..11; divide by 4 taps its low bits (12 = 3 * 4)
   localparam logic [3:0]  PRE_LAST  = 4'hB;
   localparam logic [1:0]  DIV4_LAST = 2'h3;
   localparam logic [2:0]  OSC_LAST  = 3'h7;
   localparam logic [15:0] CNT_TOP   = 16'hFFFF;
   localparam logic [15:0] SPAN8     = 16'h0100;
   localparam logic [15:0] ONE16     = 16'h0001;

   typedef struct packed {
      logic       reload_access_select;
      logic [1:0] cycle_length_select;
      logic       intermediate_irq_enable;
      logic       overflow_irq_enable;
      logic [2:0] timebase_select;
   } cca_mode_t;

   typedef struct packed {
      logic [NCH-1:0] channel_event_flag;
      logic           intermediate_overflow_flag;
      logic           counter_overflow_flag;
   } cca_flags_t;

   typedef struct packed {
      logic wide_pwm_select;
      logic comparator_enable;
      logic rising_capture_enable;
      logic falling_capture_enable;
      logic match_flag_enable;
      logic toggle_on_match;
      logic pwm_enable;
      logic channel_irq_enable;
   } cca_chan_cfg_t;

   localparam cca_mode_t     MODE_RST = '0;
   localparam cca_chan_cfg_t CFG_RST  = '0;

   // Mask of the low 8..11 bits (or all 16 when wide)
   function automatic logic [15:0] cca_len_mask(input logic [1:0] cls,
                                                input logic       wide);
      logic [15:0] m;
      m = (SPAN8 << cls) - ONE16;
      return wide ? CNT_TOP : m;
   endfunction : cca_len_mask
endpackage : cca_pkg

// *** src/cca_top.sv ***
// Counter array: timebase, 16-bit counter, capture/compare channels, bus
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cca_top (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic [7:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic             timer_overflow,
   input  wire logic             ext_count_pin,
   input  wire logic             ext_osc_pin,
   input  wire logic             lf_osc_pin,
   input  wire logic [2:0]       channel_pin_i,
   output logic      [2:0]       channel_pin_o,
   output logic      [2:0]       channel_pin_oe,
   output logic                  irq
);
   localparam int N = cca_pkg::NCH;

   cca_pkg::cca_mode_t     mode;
   cca_pkg::cca_flags_t    flags;
   cca_pkg::cca_chan_cfg_t cfg [N];
   logic [15:0]            cpr [N];
   logic [15:0]            arr [N];
   logic [15:0]            counter;
   logic [N-1:0]           inv;
   logic [N-1:0]           out;
   logic [3:0]             pre;
   logic [2:0]             osc_div;
   logic [2:0]             lfo_div;
   logic [2:0]             xs1, xs2, xs3;
   logic [N-1:0]           chs1, chs2, chs3, filt, filt_q;
   logic                   count_tick;
   logic                   cnt_new;
   logic                   ovf_evt, mid_evt;
   logic [15:0]            mid_mask;
   logic                   wr;
   logic [7:0]             wd;
   logic [3:0]             ch_ofs;
   logic [1:0]             ch_idx;
   logic                   ch_hit;
   logic [31:0]            rd_word;
   logic [N-1:0]           cap_mode, m16, m8, pm, po, cap_evt;
   logic [N-1:0]           freq_hit, ch_evt, next_out, wr_low, wr_high;
   logic [N-1:0]           ie, rel_hit;

   // Pin synchronisers: first stage feeds only the second
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         xs1 <= '0;
         xs2 <= '0;
         xs3 <= '0;
      end else begin
         xs1 <= {lf_osc_pin, ext_osc_pin, ext_count_pin};
         xs2 <= xs1;
         xs3 <= xs2;
      end
   end

   // Level is accepted only once two samples agree
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chs1   <= '0;
         chs2   <= '0;
         chs3   <= '0;
         filt   <= '0;
         filt_q <= '0;
      end else begin
         chs1   <= channel_pin_i;
         chs2   <= chs1;
         chs3   <= chs2;
         filt   <= (chs2 & ~(chs2 ^ chs3)) | (filt & (chs2 ^ chs3));
         filt_q <= filt;
      end
   end

   // Prescaler and oscillator dividers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pre     <= '0;
         osc_div <= '0;
         lfo_div <= '0;
      end else begin
         pre <= (pre == cca_pkg::PRE_LAST) ? '0 : pre + 4'h1;
         if (xs2[1] && !xs3[1])
            osc_div <= osc_div + 3'h1;
         if (xs2[2] && !xs3[2])
            lfo_div <= lfo_div + 3'h1;
      end
   end

   // Timebase selection; reserved code stops the counter
   always_comb begin
      count_tick = 1'b0;
      case (mode.timebase_select)
         cca_pkg::TB_DIV12: count_tick = (pre == cca_pkg::PRE_LAST);
         cca_pkg::TB_DIV4:  count_tick = (pre[1:0] == cca_pkg::DIV4_LAST);
         cca_pkg::TB_TMR:   count_tick = timer_overflow;
         cca_pkg::TB_ECI:   count_tick = !xs2[0] && xs3[0];
         cca_pkg::TB_SYS:   count_tick = 1'b1;
         cca_pkg::TB_EXT8:  count_tick = xs2[1] && !xs3[1] &&
                                         osc_div == cca_pkg::OSC_LAST;
         cca_pkg::TB_LFO8:  count_tick = xs2[2] && !xs3[2] &&
                                         lfo_div == cca_pkg::OSC_LAST;
         default:           count_tick = 1'b0;
      endcase
   end

   assign mid_mask = cca_pkg::cca_len_mask(mode.cycle_length_select,
                                           1'b0);
   assign ovf_evt  = count_tick && counter == cca_pkg::CNT_TOP;
   assign mid_evt  = count_tick && (counter & mid_mask) == mid_mask;

   // Bus decode: one wait cycle, then the access completes
   assign wr     = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign wd     = avs_writedata[7:0];
   assign ch_ofs = avs_address[3:0];
   assign ch_idx = 2'(avs_address[7:4] - cca_pkg::CH_FIRST);
   assign ch_hit = avs_address[7:4] >= cca_pkg::CH_FIRST &&
                   avs_address[7:4] < cca_pkg::CH_FIRST + 4'(N);

   // Channel mode decode and match detection
   always_comb begin
      logic [15:0] nm;
      nm = '0;
      for (int n = 0; n < N; n++) begin
         // PWM length is shared unless the channel is wide
         nm = cca_pkg::cca_len_mask(mode.cycle_length_select,
                                    cfg[n].wide_pwm_select);
         ie[n]       = cfg[n].channel_irq_enable;
         // Capture when match, toggle and PWM are all clear
         cap_mode[n] = !cfg[n].match_flag_enable &&
                       !cfg[n].toggle_on_match && !cfg[n].pwm_enable;
         cap_evt[n]  = cap_mode[n] &&
                       ((cfg[n].rising_capture_enable &&
                         filt[n] && !filt_q[n]) ||
                        (cfg[n].falling_capture_enable &&
                         !filt[n] && filt_q[n]));
         // Compare once per counter value, in the cycle after it moved
         m16[n] = cnt_new && counter == cpr[n];
         m8[n]  = cnt_new && counter[7:0] == cpr[n][7:0];
         pm[n]  = cnt_new && (counter & nm) == (cpr[n] & nm);
         po[n]  = cnt_new && (counter & nm) == '0;
         freq_hit[n] = cfg[n].comparator_enable &&
                       cfg[n].toggle_on_match && cfg[n].pwm_enable &&
                       m8[n];
         rel_hit[n]  = cfg[n].pwm_enable && !cfg[n].toggle_on_match &&
                       !cfg[n].wide_pwm_select && po[n];
         // Flags fire whatever the interrupt enables say
         ch_evt[n] = cap_evt[n] ||
            (cfg[n].comparator_enable && cfg[n].match_flag_enable &&
             !cfg[n].pwm_enable && m16[n]) ||
            (cfg[n].toggle_on_match && cfg[n].pwm_enable &&
             cfg[n].match_flag_enable && m16[n]) ||
            (cfg[n].pwm_enable && !cfg[n].toggle_on_match &&
             cfg[n].match_flag_enable && cfg[n].comparator_enable &&
             pm[n]);
         next_out[n] = out[n];
         if (cfg[n].comparator_enable && cfg[n].match_flag_enable &&
             cfg[n].toggle_on_match && !cfg[n].pwm_enable && m16[n])
            next_out[n] = !out[n];
         if (freq_hit[n])
            next_out[n] = !out[n];
         if (cfg[n].pwm_enable && !cfg[n].toggle_on_match) begin
            // Match beats overflow so a zero compare gives 100%
            if (!cfg[n].comparator_enable)
               next_out[n] = 1'b0;
            else if (pm[n])
               next_out[n] = 1'b1;
            else if (po[n])
               next_out[n] = 1'b0;
         end
         wr_low[n]  = wr && ch_hit && ch_idx == 2'(n) &&
                      ch_ofs == cca_pkg::OFS_LOW;
         wr_high[n] = wr && ch_hit && ch_idx == 2'(n) &&
                      ch_ofs == cca_pkg::OFS_HIGH;
      end
   end

   // Counter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         counter <= '0;
         cnt_new <= 1'b0;
      end else begin
         cnt_new <= count_tick;
         if (wr && avs_address == cca_pkg::REG_COUNT)
            counter <= avs_writedata[15:0];
         else if (count_tick)
            counter <= counter + cca_pkg::ONE16;
      end
   end

   // Global control registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode <= cca_pkg::MODE_RST;
         inv  <= '0;
      end else if (wr) begin
         if (avs_address == cca_pkg::REG_MODE)
            mode <= wd;
         if (avs_address == cca_pkg::REG_POL)
            inv <= wd[N-1:0];
      end
   end

   // Sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flags <= '0;
      end else begin
         if (wr && avs_address == cca_pkg::REG_FLAG)
            flags <= (flags & ~wd[$bits(flags)-1:0]) |
                     {ch_evt, mid_evt, ovf_evt};
         else
            flags <= flags | {ch_evt, mid_evt, ovf_evt};
      end
   end

   // Channel configuration and compare storage
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int n = 0; n < N; n++) begin
            cfg[n] <= cca_pkg::CFG_RST;
            cpr[n] <= '0;
            arr[n] <= '0;
         end
      end else begin
         for (int n = 0; n < N; n++) begin
            if (cap_evt[n])
               cpr[n] <= counter;
            // Adding 0x00 leaves the low byte, i.e. 256 counts
            if (freq_hit[n])
               cpr[n][7:0] <= cpr[n][7:0] + cpr[n][15:8];
            if (rel_hit[n]) begin
               if (mode.cycle_length_select == '0)
                  cpr[n][7:0] <= cpr[n][15:8];
               else
                  cpr[n] <= arr[n];
            end
            if (wr && ch_hit && ch_idx == 2'(n) &&
                ch_ofs == cca_pkg::OFS_CFG)
               cfg[n] <= wd;
            // Low byte first: it stops the comparator until high lands
            if (wr_low[n])
               cfg[n].comparator_enable <= 1'b0;
            if (wr_high[n])
               cfg[n].comparator_enable <= 1'b1;
            if (wr_low[n] && !mode.reload_access_select)
               cpr[n][7:0] <= wd;
            if (wr_high[n] && !mode.reload_access_select)
               cpr[n][15:8] <= wd;
            if (wr_low[n] && mode.reload_access_select)
               arr[n][7:0] <= wd;
            if (wr_high[n] && mode.reload_access_select)
               arr[n][15:8] <= wd;
         end
      end
   end

   // Outputs; polarity acts only on the pin
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out            <= '0;
         channel_pin_o  <= '0;
         channel_pin_oe <= '0;
         irq            <= 1'b0;
      end else begin
         out            <= next_out;
         channel_pin_o  <= next_out ^ inv;
         channel_pin_oe <= ~cap_mode;
         irq <= |(flags.channel_event_flag & ie) ||
                (flags.counter_overflow_flag &&
                 mode.overflow_irq_enable) ||
                (flags.intermediate_overflow_flag &&
                 mode.intermediate_irq_enable);
      end
   end

   // Read mux
   always_comb begin
      rd_word = '0;
      if (avs_address == cca_pkg::REG_MODE)
         rd_word[7:0] = mode;
      else if (avs_address == cca_pkg::REG_FLAG)
         rd_word[$bits(flags)-1:0] = flags;
      else if (avs_address == cca_pkg::REG_COUNT)
         rd_word[15:0] = counter;
      else if (avs_address == cca_pkg::REG_POL)
         rd_word[N-1:0] = inv;
      else if (ch_hit) begin
         case (ch_ofs)
            cca_pkg::OFS_CFG:  rd_word[7:0] = cfg[ch_idx];
            cca_pkg::OFS_LOW:  rd_word[7:0] = mode.reload_access_select ?
                                  arr[ch_idx][7:0] : cpr[ch_idx][7:0];
            cca_pkg::OFS_HIGH: rd_word[7:0] = mode.reload_access_select ?
                                  arr[ch_idx][15:8] : cpr[ch_idx][15:8];
            default:           rd_word = '0;
         endcase
      end
   end

   // Avalon slave: waitrequest drops for exactly one cycle per access
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest)
            avs_readdata <= rd_word;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_freq_hit0;
      freq_hit[0] && !wr;
   endsequence

   sequence s_pwm_dark0;
      cfg[0].pwm_enable && !cfg[0].toggle_on_match &&
      !cfg[0].comparator_enable;
   endsequence

   a_irq_gate: assert property (
      (|(flags.channel_event_flag & ie)) |=> irq)
      else $error("enabled channel flag did not raise irq");
   a_ovf_wrap: assert property (
      ovf_evt && !wr |=> flags.counter_overflow_flag && counter == '0)
      else $error("counter wrap missed overflow flag");
   a_mid_flag: assert property (
      count_tick && (counter & mid_mask) == mid_mask
      |=> flags.intermediate_overflow_flag)
      else $error("intermediate overflow flag missed");
   a_cap_load: assert property (
      cap_evt[0] && !wr
      |=> cpr[0] == $past(counter) && flags.channel_event_flag[0])
      else $error("capture did not load counter");
   a_swt_flag: assert property (
      cfg[0].comparator_enable && cfg[0].match_flag_enable &&
      !cfg[0].toggle_on_match && !cfg[0].pwm_enable && m16[0]
      |=> flags.channel_event_flag[0])
      else $error("software timer match lost");
   a_hso_toggle: assert property (
      cfg[0].comparator_enable && cfg[0].match_flag_enable &&
      cfg[0].toggle_on_match && !cfg[0].pwm_enable && m16[0]
      |=> out[0] != $past(out[0]))
      else $error("high speed output did not toggle");
   a_freq_step: assert property (
      s_freq_hit0 |=> out[0] != $past(out[0]) &&
      cpr[0][7:0] == 8'($past(cpr[0][7:0]) + $past(cpr[0][15:8])))
      else $error("frequency step wrong");
   a_pwm_dark: assert property (
      s_pwm_dark0 ##1 s_pwm_dark0 |=> !out[0])
      else $error("pwm output not held low");
   a_low_clear: assert property (
      wr_low[0] |=> !cfg[0].comparator_enable ##1
      cfg[0].comparator_enable == $past(cfg[0].comparator_enable))
      else $error("low byte write kept comparator on");
   a_flag_hold: assert property (
      flags.channel_event_flag[0] &&
      !(wr && avs_address == cca_pkg::REG_FLAG && wd[2])
      |=> flags.channel_event_flag[0])
      else $error("channel flag dropped without clear");
endmodule : cca_top

// *** tb/cca_pin_partner.sv ***
// Far-side driver of the channel pins; levels held long enough to count
`timescale 1ns/1ps
module cca_pin_partner (
   input  wire logic       mclk,
   input  wire logic [2:0] pin_o,
   input  wire logic [2:0] pin_oe,
   output logic      [2:0] pin_i
);
   logic [2:0] drive;
   initial drive = 3'h0;
   // The design owns the wire wherever it enables its driver
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & drive);
   task automatic set_level(input int ch, input logic v);
      @(posedge mclk);
      drive[ch] <= v;
      repeat (4) @(posedge mclk);
   endtask : set_level
   // One-cycle pulse, shorter than the filter accepts
   task automatic glitch(input int ch);
      @(posedge mclk);
      drive[ch] <= ~drive[ch];
      @(posedge mclk);
      drive[ch] <= ~drive[ch];
      repeat (4) @(posedge mclk);
   endtask : glitch
endmodule : cca_pin_partner

// *** tb/cca_top_tb_top.sv ***
// Self-checking bench of the counter array over its register bus
`timescale 1ns/1ps
module cca_top_tb_top;
   logic        mclk, resetn, avs_read, avs_write, avs_waitrequest, irq;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [2:0]  pin_i, pin_o, pin_oe;
   logic        last_o0;
   int          failures, checks_done, cycles, gap, last_gap;
   logic [1:0]  tdiv    = 2'h0;
   int          div[7]  = '{12, 4, 1, 4, 4, 32, 32};
   logic [7:0]  code[7] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h03, 8'h05,
                            8'h06};
   logic [7:0]  cap[3]  = '{8'h21, 8'h11, 8'h31};
   logic [31:0] fr[3]   = '{32'h4, 32'h0, 32'h4};
   logic [31:0] ff[3]   = '{32'h0, 32'h4, 32'h4};

   cca_top i_cca_top (.mclk(mclk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .timer_overflow(tdiv == 2'h3), .ext_count_pin(tdiv[1]),
      .ext_osc_pin(tdiv[1]), .lf_osc_pin(tdiv[1]),
      .channel_pin_i(pin_i), .channel_pin_o(pin_o),
      .channel_pin_oe(pin_oe), .irq(irq));
   cca_pin_partner i_cca_pin_partner (.mclk(mclk), .pin_o(pin_o),
      .pin_oe(pin_oe), .pin_i(pin_i));

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // Slow sources: one edge in four puts the external inputs at mclk/4
   always @(posedge mclk) tdiv <= tdiv + 2'h1;

   // Edge-to-edge spacing of channel 0 output
   always @(posedge mclk) begin
      gap <= (pin_o[0] !== last_o0) ? 1 : gap + 1;
      if (pin_o[0] !== last_o0) last_gap <= gap;
      last_o0 <= pin_o[0];
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= ~w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic chk_rd(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
      bus(1'b0, a, 16'h0000);
      check(nm, rd, exp);
   endtask : chk_rd

   // Counter is stopped while loaded so the start value is exact
   task automatic run(input logic [7:0] md, input logic [15:0] s,
                      input int n);
      bus(1'b1, cca_pkg::REG_MODE, {8'h00, md | 8'h07});
      bus(1'b1, cca_pkg::REG_COUNT, s);
      bus(1'b1, cca_pkg::REG_MODE, {8'h00, md});
      repeat (n) @(posedge mclk);
      bus(1'b1, cca_pkg::REG_MODE, {8'h00, md | 8'h07});
   endtask : run

   initial begin
      resetn = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check("oe_rst", pin_oe, 3'h0);
      check("irq_rst", irq, 1'b0);
      chk_rd("mode_rst", cca_pkg::REG_MODE, 32'h0);
      chk_rd("unmapped", 8'hFC, 32'h0);
      avs_byteenable <= 4'hE;
      bus(1'b1, cca_pkg::REG_MODE, 16'h0005);
      avs_byteenable <= 4'hF;
      chk_rd("mode_be", cca_pkg::REG_MODE, 32'h0);
      for (int i = 0; i < 7; i++) begin
         run(code[i], 16'h0000, 240);
         bus(1'b0, cca_pkg::REG_COUNT, 16'h0000);
         check("rate", rd >= 240 / div[i] - 1 && rd <= 246 / div[i] + 1,
               1);
      end
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      run(8'h04, 16'hFFF0, 40);
      chk_rd("ovf", cca_pkg::REG_FLAG, 32'h3);
      check("irq_off", irq, 1'b0);
      bus(1'b1, cca_pkg::REG_MODE, 16'h000F);
      repeat (2) @(posedge mclk);
      check("irq_on", irq, 1'b1);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h0001);
      chk_rd("w1c", cca_pkg::REG_FLAG, 32'h2);
      check("irq_mask", irq, 1'b0);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      run(8'h64, 16'h03F0, 40);
      chk_rd("intermediate_overflow_flag_10", cca_pkg::REG_FLAG, 32'h0);
      run(8'h64, 16'h07F0, 40);
      chk_rd("intermediate_overflow_flag_11", cca_pkg::REG_FLAG, 32'h2);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      bus(1'b1, cca_pkg::REG_COUNT, 16'h1234);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h10, {8'h00, cap[i]});
         i_cca_pin_partner.set_level(0, 1'b1);
         repeat (8) @(posedge mclk);
         chk_rd("cap_rise", cca_pkg::REG_FLAG, fr[i]);
         bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
         i_cca_pin_partner.set_level(0, 1'b0);
         repeat (8) @(posedge mclk);
         chk_rd("cap_fall", cca_pkg::REG_FLAG, ff[i]);
         bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      end
      bus(1'b1, 8'h10, 16'h0021);
      i_cca_pin_partner.set_level(0, 1'b1);
      repeat (8) @(posedge mclk);
      check("cap_irq", irq, 1'b1);
      chk_rd("cap_low", 8'h14, 32'h34);
      chk_rd("cap_high", 8'h18, 32'h12);
      bus(1'b1, cca_pkg::REG_MODE, 16'h00E7);
      chk_rd("reload_sel", 8'h14, 32'h0);
      bus(1'b1, cca_pkg::REG_MODE, 16'h0067);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      bus(1'b1, 8'h20, 16'h0030);
      i_cca_pin_partner.glitch(1);
      repeat (8) @(posedge mclk);
      chk_rd("glitch", cca_pkg::REG_FLAG, 32'h0);
      bus(1'b1, 8'h20, 16'h0048);
      bus(1'b1, 8'h24, 16'h0000);
      chk_rd("low_clr", 8'h20, 32'h08);
      bus(1'b1, 8'h28, 16'h0001);
      chk_rd("high_set", 8'h20, 32'h48);
      bus(1'b1, 8'h30, 16'h000C);
      bus(1'b1, 8'h34, 16'h0000);
      bus(1'b1, 8'h38, 16'h0001);
      run(8'h04, 16'h00F0, 40);
      // Passing 0xFF with 8-bit length also raises the intermediate flag
      chk_rd("match", cca_pkg::REG_FLAG, 32'h1A);
      check("hso_pin", pin_o[2], 1'b1);
      check("hso_oe", pin_oe[2], 1'b1);
      bus(1'b1, cca_pkg::REG_POL, 16'h0004);
      @(posedge mclk);
      check("pol", pin_o[2], 1'b0);
      bus(1'b1, 8'h34, 16'h0000);
      run(8'h04, 16'h00F0, 40);
      check("hold", pin_o[2], 1'b0);
      bus(1'b1, 8'h10, 16'h0046);
      bus(1'b1, 8'h14, 16'h0010);
      bus(1'b1, 8'h18, 16'h0020);
      run(8'h04, 16'h0000, 100);
      check("freq_32", last_gap, 32);
      bus(1'b1, 8'h14, 16'h0010);
      bus(1'b1, 8'h18, 16'h0000);
      run(8'h04, 16'h0000, 600);
      check("freq_256", last_gap, 256);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      bus(1'b1, 8'h10, 16'h004E);
      run(8'h04, 16'h0000, 40);
      chk_rd("freq_flag", cca_pkg::REG_FLAG, 32'h04);
      bus(1'b1, 8'h10, 16'h0046);
      bus(1'b1, cca_pkg::REG_FLAG, 16'h001F);
      bus(1'b1, 8'h20, 16'h004A);
      bus(1'b1, 8'h24, 16'h0080);
      bus(1'b1, 8'h28, 16'h0080);
      run(8'h04, 16'h0000, 150);
      chk_rd("pwm_flag", cca_pkg::REG_FLAG, 32'h08);
      check("pwm_hi", pin_o[1], 1'b1);
      bus(1'b1, 8'h24, 16'h0080);
      run(8'h04, 16'h0000, 150);
      check("pwm_off", pin_o[1], 1'b0);
      // Wide channel ignores the shared 8-bit length: 0x80 is no match
      bus(1'b1, 8'h20, 16'h00CA);
      bus(1'b1, 8'h24, 16'h0080);
      bus(1'b1, 8'h28, 16'h0001);
      run(8'h04, 16'h0000, 150);
      check("pwm_wide", pin_o[1], 1'b0);
      run(8'h04, 16'h0170, 40);
      check("pwm_wide_hit", pin_o[1], 1'b1);
      tally_and_finish();
   end
endmodule : cca_top_tb_top
